// ---- rar_pkg.sv ----
/*
  Shared constants for the reset and register-access block: register
  offsets, field ids, reset values and the multi-byte field decode.
  Assumes a 9-bit byte address space and 8-bit registers.
*/
package rar_pkg;
  localparam int ADDR_W = 9;
  localparam int EV_W = 4;
  // register offsets
  localparam logic [8:0] A_RATE_UP = 9'h007;
  localparam logic [8:0] A_RATE_LO = 9'h00C;
  localparam logic [8:0] A_RATE_MID = 9'h00D;
  localparam logic [8:0] A_STATUS4 = 9'h017;
  localparam logic [8:0] A_MCTRL1 = 9'h032;
  localparam logic [8:0] A_TRIM_LO = 9'h03C;
  localparam logic [8:0] A_TRIM_HI = 9'h03D;
  localparam logic [8:0] A_HOLD_LO = 9'h03E;
  localparam logic [8:0] A_HOLD_MID = 9'h03F;
  localparam logic [8:0] A_HOLD_UP = 9'h040;
  localparam logic [8:0] A_LIM_LO = 9'h041;
  localparam logic [8:0] A_LIM_HI = 9'h042;
  localparam logic [8:0] A_DIV_LO = 9'h046;
  localparam logic [8:0] A_DIV_HI = 9'h047;
  localparam logic [8:0] A_ADJ_LO = 9'h070;
  localparam logic [8:0] A_ADJ_HI = 9'h071;
  localparam logic [8:0] A_PHS_LO = 9'h077;
  localparam logic [8:0] A_PHS_HI = 9'h078;
  localparam logic [8:0] A_EV_LIVE = 9'h079;
  localparam logic [8:0] A_EV_LATCH = 9'h07A;
  localparam logic [8:0] A_EV_RISE = 9'h07B;
  localparam logic [8:0] A_EV_FALL = 9'h07C;
  localparam logic [8:0] A_IRQ_EN = 9'h07D;
  localparam logic [8:0] A_HOST_PORT = 9'h07E;
  localparam logic [8:0] A_USER_TOP = 9'h07F;
  // field positions
  localparam int SOFT_RST_BIT = 7;
  localparam int ABORT_BIT = 5;
  localparam int ABORT_IE_BIT = 4;
  localparam int HOLD_CTRL_LSB = 3;
  // reset values
  localparam logic [2:0] HOST_SEL_RST = 3'h0;
  localparam logic [2:0] OP_MODE_RST = 3'h0;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [18:0] HOLD_RST = 19'h00000;
  localparam logic [4:0] HOLD_CTRL_RST = 5'h00;
  localparam logic [9:0] LIMIT_RST = 10'h000;
  localparam logic [14:0] DIV_RST = 15'h0000;
  localparam logic [15:0] ADJ_RST = 16'h0000;
  localparam logic [7:0] EN_RST = 8'h00;
  // strap capture: edges after reset release before the synced pin is valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // multi-byte field ids
  localparam logic [2:0] F_NONE = 3'h0;
  localparam logic [2:0] F_RATE = 3'h1;
  localparam logic [2:0] F_TRIM = 3'h2;
  localparam logic [2:0] F_HOLD = 3'h3;
  localparam logic [2:0] F_LIM = 3'h4;
  localparam logic [2:0] F_DIV = 3'h5;
  localparam logic [2:0] F_ADJ = 3'h6;
  localparam logic [2:0] F_PHS = 3'h7;

  typedef enum logic [2:0] {
    MR_IDLE = 3'b001,
    MR_WSEQ = 3'b010,
    MR_RSEQ = 3'b100
  } rar_mr_e;

  function automatic logic [2:0] field_of(input logic [8:0] a);
    unique case (a)
      A_RATE_LO, A_RATE_MID, A_RATE_UP: field_of = F_RATE;
      A_TRIM_LO, A_TRIM_HI: field_of = F_TRIM;
      A_HOLD_LO, A_HOLD_MID, A_HOLD_UP: field_of = F_HOLD;
      A_LIM_LO, A_LIM_HI: field_of = F_LIM;
      A_DIV_LO, A_DIV_HI: field_of = F_DIV;
      A_ADJ_LO, A_ADJ_HI: field_of = F_ADJ;
      A_PHS_LO, A_PHS_HI: field_of = F_PHS;
      default: field_of = F_NONE;
    endcase
  endfunction : field_of

  function automatic logic [1:0] byte_of(input logic [8:0] a);
    unique case (a)
      A_RATE_MID, A_TRIM_HI, A_HOLD_MID, A_LIM_HI, A_DIV_HI,
      A_ADJ_HI, A_PHS_HI: byte_of = 2'h1;
      A_RATE_UP, A_HOLD_UP: byte_of = 2'h2;
      default: byte_of = 2'h0;
    endcase
  endfunction : byte_of

  function automatic logic [2:0] field_mask(input logic [2:0] f);
    field_mask = (f == F_RATE || f == F_HOLD) ? 3'h7 : 3'h3;
  endfunction : field_mask
endpackage : rar_pkg

// ---- rar_mr_if.sv ----
/*
  Carrier between the register front end and the multi-byte sequencer.
  Assumes both ends run on the same clock.
*/
interface rar_mr_if;
  logic rd;
  logic wr;
  logic srst;
  logic [2:0] fld;
  logic [1:0] byt;
  logic [7:0] wdata;
  logic commit;
  logic [2:0] commit_fld;
  logic abort;
  logic rfrozen;
  logic [2:0] act_fld;
  logic [23:0] stage;
  modport front (output rd, wr, srst, fld, byt, wdata,
                 input commit, commit_fld, abort, rfrozen, act_fld, stage);
  modport seq (input rd, wr, srst, fld, byt, wdata,
               output commit, commit_fld, abort, rfrozen, act_fld, stage);
endinterface : rar_mr_if

// ---- rar_reset_ctl.sv ----
/*
  Strap capture for pin-programmed defaults.
  Assumes the strap pins are asynchronous and steady around reset release.
*/
module rar_reset_ctl import rar_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] strap_pin,
  output logic [2:0] strap_val,
  output logic strap_load
);
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [1:0] settle;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= strap_pin;
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end

  // caught once per pin reset, kept across soft resets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_val <= HOST_SEL_RST;
      strap_load <= 1'b0;
    end else begin
      strap_load <= (settle == STRAP_SETTLE);
      if (settle == STRAP_SETTLE) begin
        strap_val <= pin_s2;
      end
    end
  end
endmodule : rar_reset_ctl

// ---- rar_multireg.sv ----
/*
  Multi-byte field sequencer: tracks read and write runs over one field,
  stages write bytes, signals commit and abort.
  Assumes at most one host access per cycle.
*/
module rar_multireg import rar_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  rar_mr_if.seq mr
);
  rar_mr_e state;
  logic [2:0] fld;
  logic [2:0] seen;
  logic acc;
  logic cont;
  logic [2:0] bit_m;
  logic [2:0] now_seen;

  always_comb begin
    acc = mr.rd | mr.wr;
    bit_m = 3'h1 << mr.byt;
    cont = (mr.fld == fld) && (mr.fld != F_NONE) &&
           ((state == MR_RSEQ && mr.rd) || (state == MR_WSEQ && mr.wr));
    now_seen = cont ? (seen | bit_m) : bit_m;
  end

  assign mr.rfrozen = (state == MR_RSEQ);
  assign mr.act_fld = fld;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= MR_IDLE;
      fld <= F_NONE;
      seen <= 3'h0;
    end else if (mr.srst) begin
      state <= MR_IDLE;
    end else if (acc) begin
      if (mr.fld == F_NONE || now_seen == field_mask(mr.fld)) begin
        state <= MR_IDLE;
      end else begin
        state <= mr.rd ? MR_RSEQ : MR_WSEQ;
        fld <= mr.fld;
        seen <= now_seen;
      end
    end
  end

  // any access off the running field ends it and drops its bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr.abort <= 1'b0;
      mr.commit <= 1'b0;
      mr.commit_fld <= F_NONE;
    end else begin
      mr.abort <= acc && !mr.srst && state != MR_IDLE && !cont;
      mr.commit <= mr.wr && !mr.srst && cont && now_seen == field_mask(fld);
      mr.commit_fld <= fld;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mr.stage <= 24'h000000;
    end else if (mr.wr && mr.fld != F_NONE) begin
      mr.stage[mr.byt*8 +: 8] <= mr.wdata;
    end
  end
endmodule : rar_multireg

// ---- rar_top.sv ----
/*
  Reset control and register bank with multi-byte field handling.
  Assumes a host port of address, write data and one-cycle strobes, read
  data one cycle after the read strobe, and one clock CLK_SYS.
*/
// Our own choice: the strobed register port.
// Function
// - RST returns every register to default, asynchronously; no test logic here.
// - Host port select captures its strap pins as reset releases.
// - Soft reset bit resets all but host port and the bit itself.
// - During soft reset, strapped fields reload their last captured value.
// - User registers 000h-07Fh, reserved space up to 1FFh reads zero.
// - Registers are eight bits, bit 7 most significant.
// - Writes to read-only fields are ignored; others are read-write.
// - Live status bits return the synchronised source level.
// - Latched bits set on chosen edges, clear only by writing one.
// - An enabled latched bit raises the interrupt output.
// - Configuration fields hold defaults while any reset is active.
// - Multi-byte writes commit all bytes together after every byte.
// - An interrupted write drops pending bytes and sets the abort flag.
// - First byte read freezes the rest of the field.
// - An interrupted read unfreezes and sets the abort flag.
// - Holdover top byte: upper five bits immediate, lower three sequenced.
module rar_top import rar_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // host register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // strap and event pins
  input wire logic [2:0] HOST_SEL_PIN,
  input wire logic [EV_W-1:0] EVENT_PIN,
  // live measurements from the timing core
  input wire logic [18:0] MEAS_RATE,
  input wire logic [15:0] MEAS_PHASE,
  // interrupt and soft reset
  output logic IRQ_OUT,
  output logic CORE_RST,
  // configuration to the timing core
  output logic [2:0] HOST_PORT_SEL,
  output logic [2:0] OP_MODE,
  output logic [15:0] OSC_TRIM,
  output logic [18:0] HOLDOVER_VAL,
  output logic [4:0] HOLDOVER_CTRL,
  output logic [9:0] HARD_LIMIT,
  output logic [14:0] IN_DIV,
  output logic [15:0] RATE_ADJ
);
  rar_mr_if mr ();

  logic [2:0] strap_val;
  logic strap_load;
  logic [EV_W-1:0] ev_s1;
  logic [EV_W-1:0] ev_s2;
  logic [EV_W-1:0] ev_d;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_latch;
  logic [EV_W-1:0] rise_en;
  logic [EV_W-1:0] fall_en;
  logic [7:0] irq_en;
  logic abort_flag;
  logic [18:0] snap;
  logic [2:0] cur_fld;
  logic frozen_hit;
  logic user_wr;
  logic [7:0] next_rdata;
  logic [18:0] rate_src;
  logic [15:0] phase_src;

  rar_reset_ctl u_reset_ctl (
    .clk(CLK_SYS),
    .rst(RST),
    .strap_pin(HOST_SEL_PIN),
    .strap_val(strap_val),
    .strap_load(strap_load)
  );

  rar_multireg u_multireg (
    .clk(CLK_SYS),
    .rst(RST),
    .mr(mr)
  );

  // decode and sequencer feed
  always_comb begin
    cur_fld = field_of(ADDR);
    user_wr = WR && (ADDR <= A_USER_TOP);
    frozen_hit = mr.rfrozen && (mr.act_fld == cur_fld);
  end

  assign mr.rd = RD;
  assign mr.wr = WR;
  assign mr.srst = CORE_RST;
  assign mr.fld = cur_fld;
  assign mr.byt = byte_of(ADDR);
  assign mr.wdata = WDATA;

  // event pins are asynchronous
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
    end else begin
      ev_s1 <= EVENT_PIN;
      ev_s2 <= ev_s1;
    end
  end

  // edge history keeps following the synced level through soft reset so no false edge follows it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ev_d <= '0;
    end else if (CORE_RST) begin
      ev_d <= ev_s2;
    end else begin
      ev_d <= ev_s2;
    end
  end

  always_comb begin
    ev_set = (rise_en & ev_s2 & ~ev_d) | (fall_en & ~ev_s2 & ev_d);
  end

  // soft reset bit: only a host write changes it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CORE_RST <= 1'b0;
    end else if (user_wr && ADDR == A_MCTRL1) begin
      CORE_RST <= WDATA[SOFT_RST_BIT];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OP_MODE <= OP_MODE_RST;
    end else if (CORE_RST) begin
      OP_MODE <= OP_MODE_RST;
    end else if (user_wr && ADDR == A_MCTRL1) begin
      OP_MODE <= WDATA[2:0];
    end
  end

  // strapped field: pin value after pin reset, stored value after soft reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HOST_PORT_SEL <= HOST_SEL_RST;
    end else if (strap_load) begin
      HOST_PORT_SEL <= strap_val;
    end else if (CORE_RST) begin
      HOST_PORT_SEL <= strap_val;
    end else if (user_wr && ADDR == A_HOST_PORT) begin
      HOST_PORT_SEL <= WDATA[2:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OSC_TRIM <= TRIM_RST;
    end else if (CORE_RST) begin
      OSC_TRIM <= TRIM_RST;
    end else if (mr.commit && mr.commit_fld == F_TRIM) begin
      OSC_TRIM <= mr.stage[15:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HOLDOVER_VAL <= HOLD_RST;
    end else if (CORE_RST) begin
      HOLDOVER_VAL <= HOLD_RST;
    end else if (mr.commit && mr.commit_fld == F_HOLD) begin
      HOLDOVER_VAL <= mr.stage[18:0];
    end
  end

  // upper five bits do not wait for the rest of the field
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HOLDOVER_CTRL <= HOLD_CTRL_RST;
    end else if (CORE_RST) begin
      HOLDOVER_CTRL <= HOLD_CTRL_RST;
    end else if (user_wr && ADDR == A_HOLD_UP) begin
      HOLDOVER_CTRL <= WDATA[7:HOLD_CTRL_LSB];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      HARD_LIMIT <= LIMIT_RST;
    end else if (CORE_RST) begin
      HARD_LIMIT <= LIMIT_RST;
    end else if (mr.commit && mr.commit_fld == F_LIM) begin
      HARD_LIMIT <= mr.stage[9:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      IN_DIV <= DIV_RST;
    end else if (CORE_RST) begin
      IN_DIV <= DIV_RST;
    end else if (mr.commit && mr.commit_fld == F_DIV) begin
      IN_DIV <= mr.stage[14:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RATE_ADJ <= ADJ_RST;
    end else if (CORE_RST) begin
      RATE_ADJ <= ADJ_RST;
    end else if (mr.commit && mr.commit_fld == F_ADJ) begin
      RATE_ADJ <= mr.stage[15:0];
    end
  end

  // event enables
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rise_en <= EN_RST[EV_W-1:0];
      fall_en <= EN_RST[EV_W-1:0];
      irq_en <= EN_RST;
    end else if (CORE_RST) begin
      rise_en <= EN_RST[EV_W-1:0];
      fall_en <= EN_RST[EV_W-1:0];
      irq_en <= EN_RST;
    end else if (user_wr) begin
      if (ADDR == A_EV_RISE) begin
        rise_en <= WDATA[EV_W-1:0];
      end
      if (ADDR == A_EV_FALL) begin
        fall_en <= WDATA[EV_W-1:0];
      end
      if (ADDR == A_IRQ_EN) begin
        irq_en <= WDATA;
      end
    end
  end

  // a new edge in the clearing cycle survives the clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ev_latch <= '0;
    end else if (CORE_RST) begin
      ev_latch <= '0;
    end else if (user_wr && ADDR == A_EV_LATCH) begin
      ev_latch <= (ev_latch & ~WDATA[EV_W-1:0]) | ev_set;
    end else begin
      ev_latch <= ev_latch | ev_set;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      abort_flag <= 1'b0;
    end else if (CORE_RST) begin
      abort_flag <= 1'b0;
    end else if (mr.abort) begin
      abort_flag <= 1'b1;
    end else if (user_wr && ADDR == A_STATUS4 && WDATA[ABORT_BIT]) begin
      abort_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(ev_latch & irq_en[EV_W-1:0]) ||
                 (abort_flag && irq_en[ABORT_IE_BIT]);
    end
  end

  // snapshot taken by the read that opens a run
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      snap <= 19'h00000;
    end else if (RD && !frozen_hit) begin
      if (cur_fld == F_RATE) begin
        snap <= MEAS_RATE;
      end else if (cur_fld == F_PHS) begin
        snap <= {3'h0, MEAS_PHASE};
      end
    end
  end

  // once frozen, bytes come from the snapshot until the run ends
  always_comb begin
    rate_src = frozen_hit ? snap : MEAS_RATE;
    phase_src = frozen_hit ? snap[15:0] : MEAS_PHASE;
  end

  // read mux; unmapped and reserved space read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (ADDR)
      A_RATE_LO: next_rdata = rate_src[7:0];
      A_RATE_MID: next_rdata = rate_src[15:8];
      A_RATE_UP: next_rdata = {5'h00, rate_src[18:16]};
      A_STATUS4: next_rdata = {2'h0, abort_flag, 5'h00};
      A_MCTRL1: next_rdata = {CORE_RST, 4'h0, OP_MODE};
      A_TRIM_LO: next_rdata = OSC_TRIM[7:0];
      A_TRIM_HI: next_rdata = OSC_TRIM[15:8];
      A_HOLD_LO: next_rdata = HOLDOVER_VAL[7:0];
      A_HOLD_MID: next_rdata = HOLDOVER_VAL[15:8];
      A_HOLD_UP: next_rdata = {HOLDOVER_CTRL, HOLDOVER_VAL[18:16]};
      A_LIM_LO: next_rdata = HARD_LIMIT[7:0];
      A_LIM_HI: next_rdata = {6'h00, HARD_LIMIT[9:8]};
      A_DIV_LO: next_rdata = IN_DIV[7:0];
      A_DIV_HI: next_rdata = {1'b0, IN_DIV[14:8]};
      A_ADJ_LO: next_rdata = RATE_ADJ[7:0];
      A_ADJ_HI: next_rdata = RATE_ADJ[15:8];
      A_PHS_LO: next_rdata = phase_src[7:0];
      A_PHS_HI: next_rdata = phase_src[15:8];
      A_EV_LIVE: next_rdata = {{(8-EV_W){1'b0}}, ev_s2};
      A_EV_LATCH: next_rdata = {{(8-EV_W){1'b0}}, ev_latch};
      A_EV_RISE: next_rdata = {{(8-EV_W){1'b0}}, rise_en};
      A_EV_FALL: next_rdata = {{(8-EV_W){1'b0}}, fall_en};
      A_IRQ_EN: next_rdata = irq_en;
      A_HOST_PORT: next_rdata = {5'h00, HOST_PORT_SEL};
      default: next_rdata = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end
endmodule : rar_top

// ---- rar_top_properties.sv ----
/* Port checker for rar_top.
   Assumes one clock and an active-high asynchronous reset. */
module rar_chk import rar_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // host port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // configuration
  input wire logic [2:0] HOST_SEL_PIN,
  input wire logic CORE_RST,
  input wire logic [2:0] HOST_PORT_SEL,
  input wire logic [2:0] OP_MODE,
  input wire logic [15:0] OSC_TRIM,
  input wire logic [4:0] HOLDOVER_CTRL,
  input wire logic [9:0] HARD_LIMIT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // a run only starts clean when the last access was elsewhere
  logic prev_trim;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      prev_trim <= 1'b0;
    end else if (WR || RD) begin
      prev_trim <= (ADDR == A_TRIM_LO) || (ADDR == A_TRIM_HI);
    end
  end
  sequence s_trim_lo;
    WR && ADDR == A_TRIM_LO && !prev_trim && !CORE_RST;
  endsequence
  sequence s_other;
    (WR || RD) && ADDR != A_TRIM_LO && ADDR != A_TRIM_HI && !(WR && ADDR == A_MCTRL1);
  endsequence
  property p_rst_out;
    disable iff (1'b0) RST |-> OSC_TRIM == 16'h0000 && !CORE_RST && HOST_PORT_SEL == 3'h0;
  endproperty
  property p_rd_idle;
    !$past(RD) |-> RDATA == 8'h00;
  endproperty
  property p_rsv_rd;
    RD && ADDR[8:7] != 2'h0 |=> RDATA == 8'h00;
  endproperty
  property p_soft_hold;
    CORE_RST && $past(CORE_RST) |-> OSC_TRIM == TRIM_RST && HARD_LIMIT == LIMIT_RST
      && OP_MODE == OP_MODE_RST;
  endproperty
  property p_soft_set;
    WR && ADDR == A_MCTRL1 && WDATA[7] |=> CORE_RST;
  endproperty
  property p_mctrl;
    WR && ADDR == A_MCTRL1 && !CORE_RST && !WDATA[7] |=>
      {5'h00, OP_MODE} == ($past(WDATA) & 8'h07) && !CORE_RST;
  endproperty
  property p_hold_ctrl;
    WR && ADDR == A_HOLD_UP && !CORE_RST |=> {HOLDOVER_CTRL, 3'h0} == ($past(WDATA) & 8'hF8);
  endproperty
  property p_cfg_quiet;
    !WR && !$past(WR) && !$past(WR, 2) |=> $stable(HARD_LIMIT) && $stable(OSC_TRIM);
  endproperty
  property p_strap;
    $fell(RST) |-> ##4 HOST_PORT_SEL == HOST_SEL_PIN;
  endproperty
  property p_trim_commit;
    s_trim_lo ##1 !(WR || RD) ##1 (WR && ADDR == A_TRIM_HI) |->
      ##2 OSC_TRIM == {$past(WDATA, 2), $past(WDATA, 4)};
  endproperty
  property p_trim_drop;
    s_trim_lo ##1 !(WR || RD) ##1 s_other |-> ##1 $stable(OSC_TRIM) [*3];
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not at default in reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_rsv_rd: assert property (p_rsv_rd) else $error("reserved read not zero");
  a_soft_hold: assert property (p_soft_hold) else $error("config moved in soft reset");
  a_soft_set: assert property (p_soft_set) else $error("soft reset bit not set");
  a_mctrl: assert property (p_mctrl) else $error("mode field wrong");
  a_hold_ctrl: assert property (p_hold_ctrl) else $error("holdover upper bits late");
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved without write");
  a_strap: assert property (p_strap) else $error("strap not captured");
  a_trim_commit: assert property (p_trim_commit) else $error("trim commit wrong");
  a_trim_drop: assert property (p_trim_drop) else $error("aborted trim committed");
endmodule : rar_chk

bind rar_top rar_chk chk_u (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .HOST_SEL_PIN,
  .CORE_RST, .HOST_PORT_SEL, .OP_MODE, .OSC_TRIM, .HOLDOVER_CTRL, .HARD_LIMIT);

// ---- rar_host_model.sv ----
/* Host processor model for the register port.
   Assumes a slave that never stalls and read data one cycle after RD. */
module rar_host import rar_pkg::*; (
  // host bus
  input wire logic clk,
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines flip, so stale values never pass for data
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  // quiet time after any reset; no service routine splits a run
  task automatic settle;
    repeat (5000) @(posedge clk);
  endtask : settle
  task automatic init_seq;
    for (int i = 0; i < 4; i++) begin
      wr_reg(9'h180 + 9'(i), 8'h00);
    end
  endtask : init_seq
endmodule : rar_host

// ---- testbench.sv ----
/* Self-checking bench for rar_top with a host model.
   Assumes the checker is bound from its own file. */
module testbench import rar_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b0;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, irq, core_rst;
  logic [2:0] sel_pin = 3'h5;
  logic [3:0] ev_pin = 4'h0;
  logic [18:0] m_rate = 19'h00000;
  logic [15:0] m_phase = 16'h0000;
  logic [2:0] port_sel, op_mode;
  logic [15:0] trim;
  logic [18:0] hold_val;
  logic [4:0] hold_ctrl;
  logic [14:0] in_div;
  logic [15:0] rate_adj;
  logic [31:0] r;
  logic [31:0] seed = 32'hEB3B6DBF;
  int n_fail = 0;
  int checks = 0;
  always #10 clk_sys = ~clk_sys;
  rar_host host_u (.clk(clk_sys), .addr, .wdata, .wr, .rd, .rdata);
  rar_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .HOST_SEL_PIN(sel_pin), .EVENT_PIN(ev_pin), .MEAS_RATE(m_rate),
    .MEAS_PHASE(m_phase), .IRQ_OUT(irq), .CORE_RST(core_rst), .HOST_PORT_SEL(port_sel),
    .OP_MODE(op_mode), .OSC_TRIM(trim), .HOLDOVER_VAL(hold_val), .HOLDOVER_CTRL(hold_ctrl),
    .HARD_LIMIT(), .IN_DIV(in_div), .RATE_ADJ(rate_adj));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [7:0] lo3(input logic [2:0] v);
    return {5'h00, v};
  endfunction : lo3
  task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : tick
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 8 && irq !== lvl; i++) begin
      @(negedge clk_sys);
    end
    cmp(irq, lvl);
    if (irq !== lvl) begin
      conclude();
    end
  endtask : wait_irq
  task automatic rd_cmp(input logic [8:0] a, input logic [7:0] m, input logic [7:0] e);
    host_u.rd_reg(a, d);
    cmp(d & m, e);
  endtask : rd_cmp
  initial begin
    // raised by a nonblocking write at time zero so the asynchronous reset sees an edge
    rst <= 1'b1;
    // one pulse long enough for the oscillator to settle
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    host_u.settle();
    cmp(port_sel, 3'h5);
    rd_cmp(A_HOST_PORT, 8'h07, 8'h05);
    host_u.init_seq();
    rd_cmp(9'h185, 8'hFF, 8'h00);
    host_u.wr_reg(A_TRIM_HI, 8'h12);
    host_u.wr_reg(A_TRIM_LO, 8'h34);
    tick(2);
    cmp(trim, 16'h1234);
    host_u.wr_reg(A_IRQ_EN, 8'h10);
    host_u.wr_reg(A_TRIM_LO, 8'hAA);
    rd_cmp(A_MCTRL1, 8'h80, 8'h00);
    wait_irq(1'b1);
    cmp(trim, 16'h1234);
    rd_cmp(A_STATUS4, 8'h20, 8'h20);
    host_u.wr_reg(A_STATUS4, 8'h20);
    rd_cmp(A_STATUS4, 8'h20, 8'h00);
    m_phase <= 16'hBEEF;
    m_rate <= 19'h5A5C3;
    rd_cmp(A_PHS_LO, 8'hFF, 8'hEF);
    m_phase <= 16'h0000;
    rd_cmp(A_PHS_HI, 8'hFF, 8'hBE);
    rd_cmp(A_RATE_MID, 8'hFF, 8'hA5);
    rd_cmp(A_EV_RISE, 8'h0F, 8'h00);
    rd_cmp(A_STATUS4, 8'h20, 8'h20);
    host_u.wr_reg(A_STATUS4, 8'h20);
    host_u.wr_reg(A_EV_RISE, 8'h01);
    host_u.wr_reg(A_EV_FALL, 8'h02);
    host_u.wr_reg(A_IRQ_EN, 8'h01);
    ev_pin <= 4'h3;
    tick(6);
    host_u.wr_reg(A_EV_LIVE, 8'h00);
    rd_cmp(A_EV_LIVE, 8'h0F, 8'h03);
    rd_cmp(A_EV_LATCH, 8'h0F, 8'h01);
    wait_irq(1'b1);
    ev_pin <= 4'h0;
    tick(6);
    host_u.wr_reg(A_EV_LATCH, 8'h00);
    rd_cmp(A_EV_LATCH, 8'h0F, 8'h03);
    host_u.wr_reg(A_EV_LATCH, 8'h03);
    rd_cmp(A_EV_LATCH, 8'h0F, 8'h00);
    wait_irq(1'b0);
    for (int i = 0; i < 32; i++) begin
      r = xs();
      case (r[1:0])
        2'h0: begin
          // upper bits stay zero so the soft reset bit stays clear
          host_u.wr_reg(A_MCTRL1, lo3(r[10:8]));
          tick(0);
          cmp(op_mode, r[10:8]);
          rd_cmp(A_MCTRL1, 8'h87, lo3(r[10:8]));
        end
        2'h1: rd_cmp({1'b1, r[15:8]}, 8'hFF, 8'h00);
        2'h2: begin
          host_u.wr_reg(A_TRIM_LO, r[23:16]);
          host_u.wr_reg(A_TRIM_HI, r[31:24]);
          tick(2);
          cmp(trim, r[31:16]);
        end
        default: begin
          host_u.wr_reg(A_EV_FALL, {4'h0, r[11:8]});
          rd_cmp(A_EV_FALL, 8'h0F, {4'h0, r[11:8]});
        end
      endcase
    end
    host_u.wr_reg(A_HOST_PORT, 8'h02);
    tick(1);
    cmp(port_sel, 3'h2);
    host_u.wr_reg(A_MCTRL1, 8'h80);
    host_u.wr_reg(A_TRIM_LO, 8'h55);
    host_u.wr_reg(A_TRIM_HI, 8'h66);
    tick(2);
    cmp(core_rst, 1'b1);
    cmp(trim, 16'h0000);
    cmp(port_sel, 3'h5);
    rd_cmp(A_MCTRL1, 8'h80, 8'h80);
    host_u.wr_reg(A_MCTRL1, 8'h00);
    host_u.settle();
    cmp(core_rst, 1'b0);
    host_u.wr_reg(A_DIV_HI, 8'h43);
    host_u.wr_reg(A_DIV_LO, 8'h5A);
    host_u.wr_reg(A_ADJ_LO, 8'h78);
    host_u.wr_reg(A_ADJ_HI, 8'h9A);
    tick(2);
    cmp(in_div, 19'h0435A);
    cmp(rate_adj, 19'h09A78);
    host_u.wr_reg(A_HOLD_LO, 8'h11);
    host_u.wr_reg(A_HOLD_MID, 8'h22);
    host_u.wr_reg(A_HOLD_UP, 8'h05);
    tick(2);
    cmp(hold_val, 19'h52211);
    host_u.wr_reg(A_HOLD_UP, 8'hFB);
    tick(2);
    cmp(hold_ctrl, 5'h1F);
    cmp(hold_val, 19'h52211);
    rst <= 1'b1;
    sel_pin <= 3'h3;
    tick(2);
    cmp(hold_val, 19'h00000);
    cmp(hold_ctrl, 5'h00);
    rst <= 1'b0;
    tick(5);
    cmp(port_sel, 3'h3);
    conclude();
  end
endmodule : testbench
